// [core/lccor_regs.sv]
// lccor_regs: cursor shape, shift direction, layer setup, glyph base,
// pixel scroll, cursor address and pixel depth, reached by indirect commands
// or by direct register address; also composes one pixel from three layers.
// assumes host strobes are single-cycle and synchronous to CLOCK.
`timescale 1ns/1ns
// Functional notes
// RQ1: cursor width field is horizontal size in pixels minus one.
// RQ2: host keeps cursor width at most the horizontal character size.
// RQ3: style bit 7 clear gives underscore, set gives block cursor.
// RQ4: host sets block cursor style when graphics mode is used.
// RQ5: height field minus one: underscore line or block height.
// RQ6: host keeps vertical cursor size within vertical character size.
// RQ7: two-bit direction applied after each access; commands 4C-4F set it.
// RQ8: left/right step one address, up/down step the address pitch.
// RQ9: cursor steps in address units even with nine-pixel characters.
// RQ10: overlay bit 4 picks two or three layers.
// RQ11: bit 3 block 3, bit 2 block 1: zero text, one graphics.
// RQ12: screen blocks 2 and 4 are always graphics.
// RQ13: composition: OR, XOR-then-OR, AND-then-OR, code 3 reserved.
// RQ14: third layer unused when first layer is text.
// RQ15: glyph address is base plus code times character height.
// RQ16: whole display shifts by the three-bit pixel scroll.
// RQ17: host keeps pixel scroll zero except at one bit per pixel.
// RQ18: host sets bytes per row one above visible characters for scroll.
// RQ19: memory accesses use cursor address; only write or increment change it.
// RQ20: without a new address, accesses continue from the advanced address.
// RQ21: cursor read returns low byte then high byte.
// RQ22: depth field 00 one, 01 two, 10 four bits per pixel.
// RQ23: memory write enables a disabled cursor; both accesses advance it.
module lccor_regs
  import lccor_pkg::*;
#(
  parameter int AW = 16
)(
  input  wire logic          CLOCK,
  input  wire logic          RST_N,
  input  wire logic          CLK_EN,
  input  wire lccor_host_t   HOST,
  input  wire logic          DIRECT_WR,
  input  wire logic          DIRECT_RD,
  input  wire logic [15:0]   DIRECT_ADDR,
  input  wire logic [AW-1:0] ADDR_PITCH,
  input  wire logic [7:0]    GLYPH_CODE,
  input  wire logic [3:0]    CHAR_HEIGHT,
  input  wire logic          PIX_L1,
  input  wire logic          PIX_L2,
  input  wire logic          PIX_L3,
  output logic [7:0]         RD_DATA,
  output logic               RD_VALID,
  output logic [AW-1:0]      MEM_ADDR,
  output logic               MEM_WR,
  output logic               MEM_RD,
  output logic [7:0]         MEM_WDATA,
  output logic [3:0]         CURSOR_WIDTH,
  output logic [3:0]         CURSOR_HEIGHT,
  output logic               CURSOR_BLOCK,
  output logic               CURSOR_ENABLED,
  output lccor_layer_t       LAYER,
  output logic               LAYER3_USED,
  output logic               PIX_OUT,
  output logic [2:0]         PIXEL_SCROLL,
  output lccor_bpp_t         PIXEL_DEPTH,
  output logic [15:0]        GLYPH_ADDR
);

  typedef enum {S_IDLE, S_SHAPE, S_LAYER, S_GLYPH, S_SCROLL, S_CURW, S_CURR,
                S_DEPTH, S_MEMORY_WRITE_COMMAND, S_MEMORY_READ_COMMAND} lccor_state_t;

  lccor_state_t   state_q;
  logic [1:0]     pidx_q;
  logic [7:0]     cw_q, ch_q, ov_q, gl_q, gh_q, hs_q, bpp_q;
  lccor_dir_t     dir_q;
  logic [AW-1:0]  cur_q;
  logic [AW-1:0]  cur_d;
  logic           step;

  // next cursor after one access, in address units even for 9-wide chars
  function automatic logic [AW-1:0] advance(input logic [AW-1:0] a,
                                            input lccor_dir_t d,
                                            input logic [AW-1:0] p);
    unique case (d)
      DIR_RIGHT: advance = a + AW'(ONE_STEP); // see RQ8 see RQ9
      DIR_LEFT:  advance = a - AW'(ONE_STEP);
      DIR_UP:    advance = a - p;
      DIR_DOWN:  advance = a + p;
    endcase
  endfunction

  // direct-address write hit
  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = DIRECT_WR && (a == r);
  endfunction

  // a memory access in either mode advances the cursor
  assign step  = (state_q inside {S_MEMORY_WRITE_COMMAND, S_MEMORY_READ_COMMAND}) && (HOST.par_wr || HOST.par_rd);
  assign cur_d = advance(cur_q, dir_q, ADDR_PITCH); // see RQ7 see RQ20

  // command decoder and parameter sequencing
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= S_IDLE;
      pidx_q  <= 2'h0;
    end
    else if (CLK_EN)
    begin
      if (HOST.cmd_wr)
      begin
        pidx_q <= 2'h0;
        unique case (HOST.data)
          CMD_SHAPE:      state_q <= S_SHAPE;
          CMD_LAYER:      state_q <= S_LAYER;
          CMD_GLYPH_BASE: state_q <= S_GLYPH;
          CMD_SCROLL:     state_q <= S_SCROLL;
          CMD_CUR_WRITE:  state_q <= S_CURW;
          CMD_CUR_READ:   state_q <= S_CURR;
          CMD_DEPTH:      state_q <= S_DEPTH;
          CMD_MEM_WRITE:  state_q <= S_MEMORY_WRITE_COMMAND;
          CMD_MEM_READ:   state_q <= S_MEMORY_READ_COMMAND;
          default:        state_q <= S_IDLE;
        endcase
      end
      else if (HOST.par_wr || HOST.par_rd)
        pidx_q <= pidx_q + 2'h1;
    end
  end

  // parameter and direct writes into the register bank
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cw_q <= RST_BYTE; ch_q <= RST_BYTE; ov_q <= RST_BYTE; gl_q <= RST_BYTE;
      gh_q <= RST_BYTE; hs_q <= RST_BYTE; bpp_q <= RST_BYTE; dir_q <= DIR_RIGHT;
    end
    else if (CLK_EN)
    begin
      // direction carried in the command byte itself
      if (HOST.cmd_wr && HOST.data[7:2] == CMD_DIR_PREFIX)
        dir_q <= lccor_dir_t'(HOST.data[DIR_MSB:0]); // see RQ7
      if (hit(DIRECT_ADDR, ADR_SHIFT_DIR))
        dir_q <= lccor_dir_t'(HOST.data[DIR_MSB:0]);
      if ((HOST.par_wr && state_q == S_SHAPE && pidx_q == 2'h0)
          || hit(DIRECT_ADDR, ADR_CURSOR_WIDTH))
        cw_q <= {4'h0, HOST.data[NIB_MSB:0]}; // see RQ1
      if ((HOST.par_wr && state_q == S_SHAPE && pidx_q == 2'h1)
          || hit(DIRECT_ADDR, ADR_CURSOR_HEIGHT))
        ch_q <= {HOST.data[STYLE_BIT], 3'h0, HOST.data[NIB_MSB:0]}; // see RQ3 see RQ5
      if ((HOST.par_wr && state_q == S_LAYER) || hit(DIRECT_ADDR, ADR_LAYER_OVERLAY))
        ov_q <= {3'h0, HOST.data[THREE_LAYER_B:0]}; // see RQ10 see RQ11
      if ((HOST.par_wr && state_q == S_GLYPH && pidx_q == 2'h0)
          || hit(DIRECT_ADDR, ADR_GLYPH_BASE_LO))
        gl_q <= HOST.data;
      if ((HOST.par_wr && state_q == S_GLYPH && pidx_q == 2'h1)
          || hit(DIRECT_ADDR, ADR_GLYPH_BASE_HI))
        gh_q <= HOST.data;
      if ((HOST.par_wr && state_q == S_SCROLL) || hit(DIRECT_ADDR, ADR_PIXEL_SCROLL))
        hs_q <= {5'h0, HOST.data[SCROLL_MSB:0]}; // see RQ16
      if ((HOST.par_wr && state_q == S_DEPTH) || hit(DIRECT_ADDR, ADR_PIXEL_DEPTH))
        bpp_q <= {6'h0, HOST.data[DEPTH_MSB:0]}; // see RQ22
    end
  end

  // cursor address: only a cursor write or an access moves it
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
      cur_q <= AW'(RST_WORD);
    else if (CLK_EN)
    begin
      if ((HOST.par_wr && state_q == S_CURW && pidx_q == 2'h0)
          || hit(DIRECT_ADDR, ADR_CURSOR_WR_LO))
        cur_q[7:0] <= HOST.data; // see RQ19
      else if ((HOST.par_wr && state_q == S_CURW && pidx_q == 2'h1)
               || hit(DIRECT_ADDR, ADR_CURSOR_WR_HI))
        cur_q[AW-1:8] <= HOST.data[AW-9:0];
      else if (step)
        cur_q <= cur_d; // see RQ8 see RQ20
    end
  end

  // memory strobes use the cursor as the access address
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      MEM_ADDR <= '0; MEM_WR <= 1'b0; MEM_RD <= 1'b0; MEM_WDATA <= RST_BYTE;
      CURSOR_ENABLED <= 1'b0;
    end
    else if (CLK_EN)
    begin
      MEM_WR    <= HOST.par_wr && state_q == S_MEMORY_WRITE_COMMAND;
      MEM_RD    <= HOST.par_rd && state_q == S_MEMORY_READ_COMMAND;
      MEM_ADDR  <= cur_q; // see RQ19
      MEM_WDATA <= HOST.data;
      // only a write wakes a disabled cursor; a read never does
      if (HOST.par_wr && state_q == S_MEMORY_WRITE_COMMAND)
        CURSOR_ENABLED <= 1'b1; // see RQ23
    end
  end

  // read answers: cursor low then high, or direct register readback
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RD_DATA  <= RST_BYTE;
      RD_VALID <= 1'b0;
    end
    else if (CLK_EN)
    begin
      RD_VALID <= (HOST.par_rd && state_q == S_CURR) || DIRECT_RD;
      if (HOST.par_rd && state_q == S_CURR)
        RD_DATA <= (pidx_q == 2'h0) ? cur_q[7:0] : 8'(cur_q[AW-1:8]); // see RQ21
      else if (DIRECT_RD)
        unique case (DIRECT_ADDR)
          ADR_CURSOR_WIDTH:  RD_DATA <= cw_q;
          ADR_CURSOR_HEIGHT: RD_DATA <= ch_q;
          ADR_SHIFT_DIR:     RD_DATA <= {6'h0, dir_q};
          ADR_LAYER_OVERLAY: RD_DATA <= ov_q;
          ADR_GLYPH_BASE_LO: RD_DATA <= gl_q;
          ADR_GLYPH_BASE_HI: RD_DATA <= gh_q;
          ADR_PIXEL_SCROLL:  RD_DATA <= hs_q;
          ADR_CURSOR_WR_LO,
          ADR_CURSOR_RD_LO:  RD_DATA <= cur_q[7:0];
          ADR_CURSOR_WR_HI,
          ADR_CURSOR_RD_HI:  RD_DATA <= 8'(cur_q[AW-1:8]);
          ADR_PIXEL_DEPTH:   RD_DATA <= bpp_q;
          default:           RD_DATA <= RST_BYTE;
        endcase
    end
  end

  // display-side decode of the stored fields
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CURSOR_WIDTH <= 4'h0; CURSOR_HEIGHT <= 4'h0; CURSOR_BLOCK <= 1'b0;
      LAYER <= '0; LAYER3_USED <= 1'b0; PIXEL_SCROLL <= 3'h0;
      PIXEL_DEPTH <= BPP_1; GLYPH_ADDR <= RST_WORD; PIX_OUT <= 1'b0;
    end
    else if (CLK_EN)
    begin
      CURSOR_WIDTH  <= cw_q[NIB_MSB:0];
      CURSOR_HEIGHT <= ch_q[NIB_MSB:0];
      CURSOR_BLOCK  <= ch_q[STYLE_BIT]; // see RQ3
      LAYER <= '{ov_q[THREE_LAYER_B], ov_q[BLK3_GFX_B], ov_q[BLK1_GFX_B],
                  lccor_mix_t'(ov_q[MIX_MSB:0])};
      // third layer needs three-layer mode and a graphics first layer
      LAYER3_USED  <= ov_q[THREE_LAYER_B] && ov_q[BLK1_GFX_B]; // see RQ10 see RQ14
      PIXEL_SCROLL <= hs_q[SCROLL_MSB:0]; // see RQ16
      PIXEL_DEPTH  <= lccor_bpp_t'(bpp_q[DEPTH_MSB:0]); // see RQ22
      GLYPH_ADDR   <= {gh_q, gl_q} + 16'(GLYPH_CODE * CHAR_HEIGHT); // see RQ15
      // second layer is graphics only, so it is never text-gated
      unique case (lccor_mix_t'(ov_q[MIX_MSB:0])) // see RQ12 see RQ13
        MIX_OR:  PIX_OUT <= PIX_L1 | PIX_L2 | (PIX_L3 & LAYER3_USED);
        MIX_XOR: PIX_OUT <= (PIX_L1 ^ PIX_L2) | (PIX_L3 & LAYER3_USED);
        MIX_AND: PIX_OUT <= (PIX_L1 & PIX_L2) | (PIX_L3 & LAYER3_USED);
        MIX_RSVD: PIX_OUT <= 1'b0;
      endcase
    end
  end

  // assertions
  a_write_enables_cur: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ23
    CLK_EN && HOST.par_wr && state_q == S_MEMORY_WRITE_COMMAND |=> CURSOR_ENABLED)
    else $error("memory write did not enable cursor");
  a_access_steps_cur: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ8
    CLK_EN && step && !DIRECT_WR |=> cur_q == $past(cur_d))
    else $error("cursor did not advance after access");
  a_cursor_holds: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ19
    CLK_EN && !step && !HOST.par_wr && !DIRECT_WR |=> $stable(cur_q))
    else $error("cursor moved without cause");
  a_read_low_first: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ21
    CLK_EN && HOST.par_rd && state_q == S_CURR && pidx_q == 2'h0
    |=> RD_VALID && RD_DATA == $past(cur_q[7:0]))
    else $error("cursor low byte not returned first");
  a_dir_command: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ7
    CLK_EN && HOST.cmd_wr && !DIRECT_WR && HOST.data >= CMD_DIR_RIGHT
    && HOST.data <= CMD_DIR_DOWN |=> dir_q == lccor_dir_t'($past(HOST.data[1:0])))
    else $error("direction command not applied");
  a_style_out: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ3
    CLK_EN |=> CURSOR_BLOCK == $past(ch_q[STYLE_BIT]))
    else $error("cursor style not decoded");
  a_text_no_l3: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ14
    CLK_EN && !ov_q[BLK1_GFX_B] |=> !LAYER3_USED)
    else $error("third layer used with text first layer");
  a_glyph_addr: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ15
    CLK_EN |=> GLYPH_ADDR == $past({gh_q, gl_q} + 16'(GLYPH_CODE * CHAR_HEIGHT)))
    else $error("glyph address wrong");
  a_rsvd_mix_dark: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ13
    CLK_EN && ov_q[MIX_MSB:0] == MIX_RSVD |=> !PIX_OUT)
    else $error("reserved composition did not give a dark pixel");
  // a low enable must freeze the cursor, MEM_WR and RD_VALID alike
  a_enable_freeze: assert property (@(posedge CLOCK) disable iff (!RST_N) // see RQ19
    !CLK_EN |=> $stable(cur_q) && $stable(MEM_WR) && $stable(RD_VALID))
    else $error("state moved while clock enable was low");
  // covers: one per main scenario
  c_mem_write: cover property (@(posedge CLOCK) MEM_WR);
  c_cursor_read: cover property (@(posedge CLOCK) RD_VALID && state_q == S_CURR);
  c_move_up: cover property (@(posedge CLOCK) step && dir_q == DIR_UP);
  c_three_layer: cover property (@(posedge CLOCK) LAYER3_USED && PIX_L3);

endmodule // lccor_regs

// [shared/lccor_pkg.sv]
// lccor_pkg: register map, field layout, command codes and carrier types
// for the cursor / overlay / drawing-control register group.
// assumes an 8-bit host data path and 16-bit display memory addresses.
package lccor_pkg;

  // register byte addresses
  localparam logic [15:0] ADR_CURSOR_WIDTH   = 16'h8015;
  localparam logic [15:0] ADR_CURSOR_HEIGHT  = 16'h8016;
  localparam logic [15:0] ADR_SHIFT_DIR      = 16'h8017;
  localparam logic [15:0] ADR_LAYER_OVERLAY  = 16'h8018;
  localparam logic [15:0] ADR_GLYPH_BASE_LO  = 16'h8019;
  localparam logic [15:0] ADR_GLYPH_BASE_HI  = 16'h801a;
  localparam logic [15:0] ADR_PIXEL_SCROLL   = 16'h801b;
  localparam logic [15:0] ADR_CURSOR_WR_LO   = 16'h801c;
  localparam logic [15:0] ADR_CURSOR_WR_HI   = 16'h801d;
  localparam logic [15:0] ADR_CURSOR_RD_LO   = 16'h801e;
  localparam logic [15:0] ADR_CURSOR_RD_HI   = 16'h801f;
  localparam logic [15:0] ADR_PIXEL_DEPTH    = 16'h8020;

  localparam logic [7:0]  RST_BYTE           = 8'h00;
  localparam logic [15:0] RST_WORD           = 16'h0000;

  // field positions
  localparam int NIB_MSB        = 3;
  localparam int STYLE_BIT      = 7;
  localparam int THREE_LAYER_B  = 4;
  localparam int BLK3_GFX_B     = 3;
  localparam int BLK1_GFX_B     = 2;
  localparam int MIX_MSB        = 1;
  localparam int SCROLL_MSB     = 2;
  localparam int DIR_MSB        = 1;
  localparam int DEPTH_MSB      = 1;

  // command codes
  localparam logic [7:0] CMD_SHAPE      = 8'h5d;
  localparam logic [7:0] CMD_DIR_RIGHT  = 8'h4c;
  localparam logic [7:0] CMD_DIR_DOWN   = 8'h4f;
  localparam logic [7:0] CMD_LAYER      = 8'h5b;
  localparam logic [7:0] CMD_GLYPH_BASE = 8'h5c;
  localparam logic [7:0] CMD_SCROLL     = 8'h5a;
  localparam logic [7:0] CMD_CUR_WRITE  = 8'h46;
  localparam logic [7:0] CMD_CUR_READ   = 8'h47;
  localparam logic [7:0] CMD_DEPTH      = 8'h60;
  localparam logic [7:0] CMD_MEM_WRITE  = 8'h42;
  localparam logic [7:0] CMD_MEM_READ   = 8'h43;
  localparam logic [5:0] CMD_DIR_PREFIX = 6'h13;

  localparam logic [15:0] ONE_STEP      = 16'h0001;
  localparam logic [1:0]  CURSOR_OFF    = 2'h0;
  localparam logic [1:0]  CURSOR_STEADY = 2'h1;

  typedef enum logic [1:0] {DIR_RIGHT, DIR_LEFT, DIR_UP, DIR_DOWN} lccor_dir_t;
  typedef enum logic [1:0] {MIX_OR, MIX_XOR, MIX_AND, MIX_RSVD} lccor_mix_t;
  typedef enum logic [1:0] {BPP_1, BPP_2, BPP_4, BPP_RSVD} lccor_bpp_t;

  // host strobe carrier
  typedef struct packed {
    logic        cmd_wr;
    logic        par_wr;
    logic        par_rd;
    logic [7:0]  data;
  } lccor_host_t;

  // layer / display state carrier
  typedef struct packed {
    logic        three_layer_select;
    logic        block3_graphics_select;
    logic        block1_graphics_select;
    lccor_mix_t  composition_method;
  } lccor_layer_t;

endpackage

// [verification/lccor_host_model.sv]
// lccor_host_model: host processor side, issuing indirect commands,
// parameter bytes and direct register cycles.
// assumes the block samples every strobe on the rising clock.
`timescale 1ns/1ns
module lccor_host_model
  import lccor_pkg::*;
(
  input  wire logic  clock,
  output lccor_host_t host,
  output logic        dir_wr,
  output logic        dir_rd,
  output logic [15:0] dir_addr
);
  // idle bus at time zero
  initial
  begin
    host     = '0;
    dir_wr   = 1'b0;
    dir_rd   = 1'b0;
    dir_addr = 16'h0000;
  end

  // one-cycle strobe; data then shows the inverse so a stale byte never matches
  task strobe(input logic [2:0] kind, input logic [7:0] b);
    @(posedge clock);
    host <= {kind, b};
    @(posedge clock);
    host <= {3'h0, ~b};
  endtask

  task cmd(input logic [7:0] b);
    strobe(3'h4, b);
  endtask

  task pwr(input logic [7:0] b);
    strobe(3'h2, b);
  endtask

  // parameter read; cursor bytes are always fetched low first
  task prd;
    strobe(3'h1, 8'h00);
  endtask

  // direct register cycle, held one cycle, address and data inverted afterwards
  task dacc(input logic wr, input logic [15:0] a, input logic [7:0] b);
    @(posedge clock);
    dir_wr    <= wr;
    dir_rd    <= !wr;
    dir_addr  <= a;
    host.data <= b;
    @(posedge clock);
    dir_wr    <= 1'b0;
    dir_rd    <= 1'b0;
    dir_addr  <= ~a;
    host.data <= ~b;
  endtask
endmodule // lccor_host_model

// [verification/tb_top.sv]
// tb_top: self-checking bench for the cursor / overlay register group.
// assumes the host model drives all strobes; expectations come from functions here.
`timescale 1ns/1ns
module tb_top;
  import lccor_pkg::*;
  logic         clock, rst_n, clk_en, pl1, pl2, pl3, rd_valid, mem_wr, mem_rd;
  logic         cur_blk, cur_en, l3_used, pix_out, dwr, drd, b;
  logic [15:0]  pitch, daddr, mem_addr, glyph_addr, cur, gb;
  logic [7:0]   code, rd_data, mem_wdata, wd;
  logic [4:0]   lv;
  logic [3:0]   chh, cur_w, cur_h, w, h;
  logic [2:0]   scroll, sv;
  logic [1:0]   d;
  lccor_host_t  host;
  lccor_layer_t layer;
  lccor_bpp_t   depth;
  int           err_total, checks, seed, k, j;
  logic [15:0]  regs [10] = '{ADR_CURSOR_WIDTH, ADR_CURSOR_HEIGHT, ADR_LAYER_OVERLAY,
    ADR_GLYPH_BASE_LO, ADR_GLYPH_BASE_HI, ADR_PIXEL_SCROLL, ADR_CURSOR_RD_LO,
    ADR_CURSOR_RD_HI, ADR_PIXEL_DEPTH, 16'h8030};

  lccor_host_model u_host (.clock(clock), .host(host), .dir_wr(dwr), .dir_rd(drd),
    .dir_addr(daddr));

  lccor_regs dut (.CLOCK(clock), .RST_N(rst_n), .CLK_EN(clk_en), .HOST(host),
    .DIRECT_WR(dwr), .DIRECT_RD(drd), .DIRECT_ADDR(daddr), .ADDR_PITCH(pitch),
    .GLYPH_CODE(code), .CHAR_HEIGHT(chh), .PIX_L1(pl1), .PIX_L2(pl2), .PIX_L3(pl3),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .MEM_ADDR(mem_addr), .MEM_WR(mem_wr),
    .MEM_RD(mem_rd), .MEM_WDATA(mem_wdata), .CURSOR_WIDTH(cur_w),
    .CURSOR_HEIGHT(cur_h), .CURSOR_BLOCK(cur_blk), .CURSOR_ENABLED(cur_en),
    .LAYER(layer), .LAYER3_USED(l3_used), .PIX_OUT(pix_out), .PIXEL_SCROLL(scroll),
    .PIXEL_DEPTH(depth), .GLYPH_ADDR(glyph_addr));

  // 50 MHz
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function logic [15:0] step(input logic [1:0] dd, input logic [15:0] c);
    case (dd)
      2'h0: step = c + 16'h0001;
      2'h1: step = c - 16'h0001;
      2'h2: step = c - pitch;
      default: step = c + pitch;
    endcase
  endfunction

  // reserved code composes to 0
  function logic mix(input logic [1:0] m, input logic [2:0] l);
    case (m)
      2'h0: mix = l[2] | l[1] | l[0];
      2'h1: mix = (l[2] ^ l[1]) | l[0];
      2'h2: mix = (l[2] & l[1]) | l[0];
      default: mix = 1'b0;
    endcase
  endfunction

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task end_sim;
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // bounded wait for a pulse: 0 write, 1 read, 2 read data
  task wait_for(input int sel);
    for (int i = 0; i < 4; i++)
    begin
      #1;
      if ((sel == 0 && mem_wr === 1'b1) || (sel == 1 && mem_rd === 1'b1) ||
          (sel == 2 && rd_valid === 1'b1))
        return;
      @(posedge clock);
    end
    err_total++;
    $display("[FAIL] handshake %0d expected 1 seen 0", sel);
    end_sim();
  endtask

  // overall hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    err_total++;
    $display("[FAIL] run length expected done seen hang");
    end_sim();
  end

  initial
  begin
    err_total = 0;
    checks = 0;
    seed = 32'hb7a5;
    rst_n = 1'b0;
    clk_en = 1'b1;
    pitch = 16'h0028;
    code = 8'h00;
    chh = 4'h0;
    {pl1, pl2, pl3} = 3'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    // reset values, unmapped address last
    for (k = 0; k < 10; k++)
    begin
      u_host.dacc(1'b0, regs[k], 8'h00);
      wait_for(2);
      chk("reset read", rd_data, 8'h00);
    end
    // random four-bit sizes; style alternates underscore and block
    for (k = 0; k < 4; k++)
    begin
      w = $random(seed);
      h = $random(seed);
      b = k[0];
      u_host.cmd(CMD_SHAPE);
      u_host.pwr({4'h0, w});
      u_host.pwr({b, 3'h0, h});
      wt(3);
      chk("cursor width", cur_w, w);
      chk("cursor height", cur_h, h);
      chk("cursor style", cur_blk, b);
    end
    u_host.dacc(1'b1, ADR_CURSOR_WIDTH, 8'h0a);
    wt(3);
    chk("direct width", cur_w, 4'ha);
    // enable low: a direct write must not land
    @(posedge clock);
    clk_en <= 1'b0;
    u_host.dacc(1'b1, ADR_CURSOR_WIDTH, 8'h05);
    clk_en <= 1'b1;
    wt(3);
    chk("frozen width", cur_w, 4'ha);
    // read first: advances but must leave the cursor off
    cur = $random(seed);
    @(posedge clock);
    pitch <= $random(seed);
    u_host.cmd(CMD_CUR_WRITE);
    u_host.pwr(cur[7:0]);
    u_host.pwr(cur[15:8]);
    u_host.cmd(CMD_MEM_READ);
    u_host.prd();
    wait_for(1);
    chk("read address", mem_addr, cur);
    chk("cursor off", cur_en, 1'b0);
    cur = step(2'h0, cur);
    for (k = 0; k < 4; k++)
    begin
      d = k[1:0];
      u_host.cmd({CMD_DIR_PREFIX, d});
      u_host.cmd(CMD_MEM_WRITE);
      for (j = 0; j < 2; j++)
      begin
        wd = $random(seed);
        u_host.pwr(wd);
        wait_for(0);
        chk("write address", mem_addr, cur);
        chk("write data", mem_wdata, wd);
        cur = step(d, cur);
      end
    end
    chk("cursor on", cur_en, 1'b1);
    u_host.cmd(CMD_CUR_READ);
    u_host.prd();
    wait_for(2);
    chk("cursor low", rd_data, cur[7:0]);
    u_host.prd();
    wait_for(2);
    chk("cursor high", rd_data, cur[15:8]);
    // every mix code against every layer pixel combination
    for (k = 0; k < 32; k++)
    begin
      lv = $random(seed);
      lv[1:0] = k[1:0];
      @(posedge clock);
      {pl1, pl2, pl3} <= k[4:2];
      u_host.cmd(CMD_LAYER);
      u_host.pwr({3'h0, lv});
      wt(3);
      chk("layer setup", layer, lv);
      chk("third layer use", l3_used, lv[4] & lv[2]);
      // third layer pixel only counts in three-layer mode with a graphics first layer
      chk("composed pixel", pix_out, mix(lv[1:0], {k[4:3], k[2] & lv[4] & lv[2]}));
    end
    for (k = 0; k < 4; k++)
    begin
      gb = $random(seed);
      @(posedge clock);
      code <= $random(seed);
      chh <= $random(seed);
      u_host.cmd(CMD_GLYPH_BASE);
      u_host.pwr(gb[7:0]);
      u_host.pwr(gb[15:8]);
      wt(3);
      chk("glyph address", glyph_addr, gb + code * chh);
    end
    // scroll cleared before leaving one bit per pixel
    for (k = 0; k < 3; k++)
    begin
      sv = (k == 0) ? 3'($random(seed)) : 3'h0;
      u_host.cmd(CMD_SCROLL);
      u_host.pwr({5'h0, sv});
      u_host.cmd(CMD_DEPTH);
      u_host.pwr({6'h0, k[1:0]});
      wt(3);
      chk("pixel scroll", scroll, sv);
      chk("pixel depth", depth, k[1:0]);
    end
    end_sim();
  end
endmodule // tb_top
